/* rtl/asg_defs.vh */
// Purpose : Constants for the scan gate, timebase and hold-done slice
// Assumes : 250 MHz system clock (4 ns period)
// Notes   : Times in ns; cycle counts derived from them
`ifndef ASG_DEFS_VH
`define ASG_DEFS_VH

`define ASG_CLK_MHZ          250
`define ASG_CLK_PERIOD_NS    4
// Source select codes
`define ASG_SRC_PIN_ZERO     3'h0
`define ASG_SRC_TRIG_LO      3'h1
`define ASG_SRC_STAR         3'h7
// Timebase select codes
`define ASG_TB_20M           2'h0
`define ASG_TB_100K          2'h1
`define ASG_TB_EXT           2'h2
// Internal timebase rates in kHz
`define ASG_TB_FAST_KHZ      20000
`define ASG_TB_SLOW_KHZ      100
`define ASG_TB_FAST_DIV      ((`ASG_CLK_MHZ * 1000) / `ASG_TB_FAST_KHZ)
`define ASG_TB_SLOW_DIV      ((`ASG_CLK_MHZ * 1000) / `ASG_TB_SLOW_KHZ)
// Hold-done timing in ns
`define ASG_HOLD_DLY_MIN_NS  50
`define ASG_HOLD_DLY_TOP_NS  100
`define ASG_HOLD_WID_MIN_NS  400
`define ASG_HOLD_WID_TOP_NS  500
// Least delay rounds up, width rounds up from the minimum
`define ASG_HOLD_DLY_CYC \
  ((`ASG_HOLD_DLY_MIN_NS + `ASG_CLK_PERIOD_NS - 1) / `ASG_CLK_PERIOD_NS)
`define ASG_HOLD_WID_CYC \
  ((`ASG_HOLD_WID_MIN_NS + `ASG_CLK_PERIOD_NS - 1) / `ASG_CLK_PERIOD_NS)
// Scan interval counter reset value
`define ASG_SI_RST           16'h0000

`endif

/* rtl/asg_sync_pol.v */
// Purpose : Two-flop synchroniser with polarity inversion
// Assumes : Input is asynchronous to i_clk_sys
// Notes   : First flop feeds only the second
`timescale 1ns/1ps
module asg_sync_pol (
  input  wire i_clk_sys,  // System clock
  input  wire i_sys_rst,  // Synchronous reset, active high
  input  wire i_async,    // Asynchronous level
  input  wire i_invert,   // 1 = active low source
  output reg  o_level_q   // Synchronised, active-high level
);
  reg meta_q;
  reg sync_q;

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      // Preload the idle pin level so no false edge follows reset
      meta_q    <= i_invert;
      sync_q    <= i_invert;
      o_level_q <= 1'b0;
    end else begin
      meta_q    <= i_async;
      sync_q    <= meta_q;
      o_level_q <= sync_q ^ i_invert;
    end
  end
endmodule

/* rtl/asg_scan_timing.v */
// Purpose : Scan pause gate, scan interval timebase and hold-done pulse
// Assumes : One 250 MHz clock; external pins asynchronous
// Notes   : Control bits are plain ports, no register bus
// How it works
// - Pause gate source is input zero, trigger lines 0-5 or star; none out.
// - Pause gate is level sensitive with selectable polarity.
// - Active pause gate masks scan start pulses.
// - Gate changes apply only at the next scan start.
// - Scan interval counter runs on timebase ticks and makes scan starts.
// - External timebase ticks on each rising edge of its level, with selectable polarity.
// - Otherwise timebase is internal 20 MHz or 100 kHz.
// - Hold-done leading edge 50 to 100 ns after conversion start.
// - Hold-done lasts 400 to 500 ns and only when enabled.
// - Hold-done polarity selectable, default positive.
// - Each accepted scan start, internal or external edge, begins a scan.
// - Scans outside a sequence inhibited; software gate also masks scans.
`timescale 1ns/1ps
`include "asg_defs.vh"
module asg_scan_timing #(
  parameter SI_W      = 16,                 // Scan interval counter width
  parameter SLOW_DIV  = `ASG_TB_SLOW_DIV,   // 100 kHz divider in cycles
  parameter FAST_DIV  = `ASG_TB_FAST_DIV    // 20 MHz divider in cycles
) (
  input  wire            i_clk_sys,     // System clock 250 MHz
  input  wire            i_sys_rst,     // Synchronous reset, active high
  input  wire            i_pfi_zero,    // Programmable input zero pin
  input  wire [5:0]      i_trig_line,   // Trigger lines 0 to 5
  input  wire            i_star,        // Star trigger pin
  input  wire [2:0]      i_gate_src,    // Pause gate source select
  input  wire            i_gate_inv,    // 1 = pause gate active low
  input  wire [2:0]      i_tb_src,      // External timebase source select
  input  wire [1:0]      i_tb_sel,      // 0=20 MHz 1=100 kHz 2=external
  input  wire            i_tb_inv,      // 1 = external timebase active low
  input  wire [SI_W-1:0] i_si_reload,   // Timebase ticks per scan minus 1
  input  wire            i_ext_start,   // 1 = external scan start edge
  input  wire [2:0]      i_start_src,   // External scan start source
  input  wire            i_start_inv,   // 1 = falling edge starts a scan
  input  wire            i_seq_active,  // Acquisition sequence running
  input  wire            i_sw_gate,     // Software gate, 1 masks scans
  input  wire            i_conv_strobe, // Conversion strobe, same clock
  input  wire            i_hold_en,     // Hold-done output enable
  input  wire            i_hold_inv,    // 1 = negative hold-done pulse
  output reg             o_scan_start_q,   // Accepted scan start pulse
  output reg             o_scan_gated_q,   // Latched gate decision level
  output reg             o_hold_done_q     // Hold-done pulse pin level
);
  localparam integer HOLD_DLY_I = `ASG_HOLD_DLY_CYC;
  localparam integer HOLD_WID_I = `ASG_HOLD_WID_CYC;
  localparam [7:0]   HOLD_DLY   = HOLD_DLY_I[7:0];
  localparam [7:0]   HOLD_WID   = HOLD_WID_I[7:0];
  localparam [1:0] HS_IDLE  = 2'h0;
  localparam [1:0] HS_DLY   = 2'h1;
  localparam [1:0] HS_HIGH  = 2'h2;

  // --------------------------------------------------------------
  // Source selection and synchronisers
  // --------------------------------------------------------------
  // Pin index 0 is input zero, 1 to 6 the trigger lines, 7 star
  wire [7:0] src_vec = {i_star, i_trig_line, i_pfi_zero};
  wire       gate_lvl;
  wire       tb_lvl;
  wire       st_lvl;

  asg_sync_pol u_gate_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (src_vec[i_gate_src]),
    .i_invert  (i_gate_inv),
    .o_level_q (gate_lvl)
  );
  asg_sync_pol u_tb_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (src_vec[i_tb_src]),
    .i_invert  (i_tb_inv),
    .o_level_q (tb_lvl)
  );
  asg_sync_pol u_st_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (src_vec[i_start_src]),
    .i_invert  (i_start_inv),
    .o_level_q (st_lvl)
  );

  // --------------------------------------------------------------
  // Timebase tick
  // --------------------------------------------------------------
  reg  [15:0] div_q;
  reg         tb_prev_q;
  reg         tick_q;
  // Whole-cycle divider: the fast rate lands slightly above nominal
  wire [15:0] div_top = (i_tb_sel == `ASG_TB_100K) ?
                        SLOW_DIV[15:0] - 16'h0001 :
                        FAST_DIV[15:0] - 16'h0001;

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      div_q     <= 16'h0000;
      tb_prev_q <= 1'b0;
      tick_q    <= 1'b0;
    end else begin
      tb_prev_q <= tb_lvl;
      // External rate: one tick per rising edge of the corrected level
      if (i_tb_sel == `ASG_TB_EXT) begin
        div_q  <= 16'h0000;
        tick_q <= tb_lvl & ~tb_prev_q;
      end else if (div_q >= div_top) begin
        div_q  <= 16'h0000;
        tick_q <= 1'b1;
      end else begin
        div_q  <= div_q + 16'h0001;
        tick_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // Scan interval counter and start opportunities
  // --------------------------------------------------------------
  // Reload is copied while no sequence runs; set it before starting
  reg [SI_W-1:0] si_q;
  reg            st_prev_q;
  reg            opp_q;

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      si_q      <= `ASG_SI_RST;
      st_prev_q <= 1'b0;
      opp_q     <= 1'b0;
    end else begin
      st_prev_q <= st_lvl;
      opp_q     <= 1'b0;
      if (!i_seq_active) begin
        si_q <= i_si_reload;
      end else if (i_ext_start) begin
        opp_q <= st_lvl & ~st_prev_q;
      end else if (tick_q) begin
        if (si_q == {SI_W{1'b0}}) begin
          si_q  <= i_si_reload;
          opp_q <= 1'b1;
        end else begin
          si_q <= si_q - {{(SI_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Gate decision, sampled only at a start opportunity
  // --------------------------------------------------------------
  // Only this edge may change the decision, so a running scan stays
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_scan_start_q <= 1'b0;
      o_scan_gated_q <= 1'b0;
    end else begin
      o_scan_start_q <= 1'b0;
      if (opp_q) begin
        o_scan_gated_q <= gate_lvl | i_sw_gate;
        o_scan_start_q <= i_seq_active & ~gate_lvl
                          & ~i_sw_gate;
      end
    end
  end

  // --------------------------------------------------------------
  // Hold-done pulse after each enabled conversion start in a sequence
  // --------------------------------------------------------------
  // Strobes during a pulse are dropped. The delay count is two short
  // to cover the state change and the output register.
  reg [1:0] hs_q;
  reg [7:0] hcnt_q;
  reg       hact_q;

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      hs_q   <= HS_IDLE;
      hcnt_q <= 8'h00;
      hact_q <= 1'b0;
    end else begin
      case (hs_q)
        HS_IDLE: begin
          hact_q <= 1'b0;
          if (i_conv_strobe && i_hold_en && i_seq_active) begin
            hcnt_q <= HOLD_DLY - 8'h02;
            hs_q   <= HS_DLY;
          end
        end
        HS_DLY: begin
          if (hcnt_q == 8'h00) begin
            hact_q <= 1'b1;
            hcnt_q <= HOLD_WID - 8'h01;
            hs_q   <= HS_HIGH;
          end else begin
            hcnt_q <= hcnt_q - 8'h01;
          end
        end
        HS_HIGH: begin
          if (hcnt_q == 8'h00) begin
            hact_q <= 1'b0;
            hs_q   <= HS_IDLE;
          end else begin
            hcnt_q <= hcnt_q - 8'h01;
          end
        end
        default: begin
          hs_q   <= HS_IDLE;
          hact_q <= 1'b0;
        end
      endcase
    end
  end

  always @(posedge i_clk_sys) begin
    // Reset clears the pin even when a negative pulse is selected
    if (i_sys_rst)
      o_hold_done_q <= 1'b0;
    else
      o_hold_done_q <= hact_q ^ i_hold_inv;
  end
endmodule

/* dv/asg_scan_chk.sv */
// Purpose: Port checks for the scan gate, timebase and hold-done slice
// Assumes: One clock; inputs change away from the rising edge
// Notes: Hold checks skip the first edges after reset
`timescale 1ns/1ps
module asg_scan_chk #(
  parameter SI_W = 16, SLOW_DIV = 2500, FAST_DIV = 12
) (
  input logic            i_clk_sys,      // System clock
  input logic            i_sys_rst,      // Reset, active high
  input logic            i_pfi_zero,     // Input zero pin
  input logic [5:0]      i_trig_line,    // Trigger lines
  input logic            i_star,         // Star pin
  input logic [2:0]      i_gate_src,     // Pause gate source
  input logic            i_gate_inv,     // Pause gate active low
  input logic [2:0]      i_tb_src,       // Timebase source
  input logic [1:0]      i_tb_sel,       // Timebase select
  input logic            i_tb_inv,       // Timebase active low
  input logic [SI_W-1:0] i_si_reload,    // Ticks per scan minus 1
  input logic            i_ext_start,    // External start mode
  input logic [2:0]      i_start_src,    // Start source
  input logic            i_start_inv,    // Falling edge starts
  input logic            i_seq_active,   // Sequence running
  input logic            i_sw_gate,      // Software gate
  input logic            i_conv_strobe,  // Conversion strobe
  input logic            i_hold_en,      // Hold-done enable
  input logic            i_hold_inv,     // Negative hold-done
  input logic            o_scan_start_q, // Scan start pulse
  input logic            o_scan_gated_q, // Gate decision
  input logic            o_hold_done_q   // Hold-done pin
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  wire [7:0] pins = {i_star, i_trig_line, i_pfi_zero};
  wire gate = pins[i_gate_src] ^ i_gate_inv;
  wire sst = pins[i_start_src] ^ i_start_inv;
  wire act = o_hold_done_q ^ i_hold_inv;
  wire [31:0] per = (i_si_reload + 32'd1) *
                    (i_tb_sel == 2'h1 ? SLOW_DIV : FAST_DIV);
  int since_q, wid_q, gap_q, age_q;
  logic en_q, ok_q, inv_q, inv2_q;
  // Polarity unchanged over the last two edges, pin settled
  wire inv_ok = inv_q == i_hold_inv && inv2_q == i_hold_inv;
  // Ages of strobe, pulse, scan and reset for the timing checks
  always @(posedge i_clk_sys) begin
    age_q <= i_sys_rst ? 0 : (age_q < 9 ? age_q + 1 : age_q);
    since_q <= (i_sys_rst || i_conv_strobe) ? 0 : since_q + 1;
    en_q <= i_sys_rst ? 1'b0 :
            i_conv_strobe ? (i_hold_en && i_seq_active) : en_q;
    wid_q <= act ? wid_q + 1 : 0;
    gap_q <= o_scan_start_q ? 1 : gap_q + 1;
    inv_q <= i_hold_inv;
    inv2_q <= inv_q;
    ok_q <= (i_sys_rst || !i_seq_active || i_ext_start || i_tb_sel[1]) ?
            1'b0 : (o_scan_start_q ? 1'b1 : ok_q);
  end
  start_once_a: assert property (o_scan_start_q |=> !o_scan_start_q)
    else $error("scan start wider than one cycle");
  seq_block_a: assert property (
    !i_seq_active [*4] |-> !o_scan_start_q)
    else $error("scan start outside sequence");
  sw_block_a: assert property (i_sw_gate [*4] |-> !o_scan_start_q)
    else $error("scan start under software gate");
  pause_mask_a: assert property (gate [*8] |-> !o_scan_start_q)
    else $error("scan start under pause gate");
  gate_clear_a: assert property (o_scan_start_q |-> !o_scan_gated_q)
    else $error("scan start with gated decision");
  scan_period_a: assert property (
    o_scan_start_q && ok_q |-> gap_q % per == 0)
    else $error("scan start off the interval");
  ext_start_a: assert property (
    i_ext_start && i_seq_active && !i_sw_gate && !gate && $rose(sst)
    |-> ##[2:8] o_scan_start_q)
    else $error("external edge started no scan");
  hold_lead_a: assert property (
    $rose(act) && age_q > 3 && inv_ok |-> since_q >= 13 && since_q <= 25)
    else $error("hold lead out of range");
  hold_gate_a: assert property (
    $rose(act) && age_q > 3 && inv_ok |-> en_q)
    else $error("hold pulse while disabled");
  hold_width_a: assert property (
    $fell(act) && age_q > 3 && inv_ok |-> wid_q >= 100 && wid_q <= 125)
    else $error("hold width out of range");
  hold_idle_a: assert property (
    age_q > 3 && since_q > 160 && inv_ok |-> o_hold_done_q == i_hold_inv)
    else $error("hold idle level wrong");
endmodule
bind asg_scan_timing asg_scan_chk #(
  .SI_W     (SI_W),
  .SLOW_DIV (SLOW_DIV),
  .FAST_DIV (FAST_DIV)
) u_chk (
  .i_clk_sys      (i_clk_sys),
  .i_sys_rst      (i_sys_rst),
  .i_pfi_zero     (i_pfi_zero),
  .i_trig_line    (i_trig_line),
  .i_star         (i_star),
  .i_gate_src     (i_gate_src),
  .i_gate_inv     (i_gate_inv),
  .i_tb_src       (i_tb_src),
  .i_tb_sel       (i_tb_sel),
  .i_tb_inv       (i_tb_inv),
  .i_si_reload    (i_si_reload),
  .i_ext_start    (i_ext_start),
  .i_start_src    (i_start_src),
  .i_start_inv    (i_start_inv),
  .i_seq_active   (i_seq_active),
  .i_sw_gate      (i_sw_gate),
  .i_conv_strobe  (i_conv_strobe),
  .i_hold_en      (i_hold_en),
  .i_hold_inv     (i_hold_inv),
  .o_scan_start_q (o_scan_start_q),
  .o_scan_gated_q (o_scan_gated_q),
  .o_hold_done_q  (o_hold_done_q)
);

/* dv/asg_far_src.sv */
// Purpose: Trigger sources outside the device
// Assumes: Pin 0 is input zero, 1..6 trigger lines, 7 star
// Notes: Unselected pins toggle so no stale level hides a bad select
`timescale 1ns/1ps
module asg_far_src (
  input  logic [2:0] i_gate_idx, i_tb_idx, i_st_idx, // Pin choices
  input  logic       i_gate_lvl, i_tb_run, i_st_lvl, // Levels shown
  output logic [7:0] o_pins                          // Pin levels
);
  logic tb_clk = 1'b0;
  logic noise = 1'b0;
  always #3 noise = !noise;
  // 20 MHz with 25 ns phases; stands still when not running
  always #25 tb_clk = i_tb_run ? !tb_clk : tb_clk;
  always_comb
    for (int k = 0; k < 8; k++)
      o_pins[k] = k == i_gate_idx ? i_gate_lvl : k == i_tb_idx ? tb_clk :
                  k == i_st_idx ? i_st_lvl : noise ^ k[0];
endmodule

/* dv/tb_top.sv */
// Purpose: Random tests of scan gating, timebase and hold in all four modes
// Assumes: 250 MHz clock, inputs driven on the falling edge
// Notes: Slow timebase shortened through SLOW_DIV
`timescale 1ns/1ps
module tb_top;
  localparam int SLOW = 40, FAST = 12;
  logic clk = 0, rst = 1, strobe = 0, ext = 0, sinv = 0, seq = 0, sw = 0;
  logic ginv = 0, tinv = 0, hen = 0, hinv = 0, glvl = 0, trun = 0;
  logic slvl = 0, blk, st, gated, hold;
  logic [2:0] gsrc = 0;
  logic [1:0] tsel = 0;
  logic [15:0] rl = 0;
  logic [7:0] pins;
  wire [2:0] tsrc = gsrc + 3'h1;
  wire [2:0] ssrc = gsrc + 3'h2;
  int n_errors = 0, num_checks = 0, cnt, e, first, last, mode;
  always #2 clk = !clk;
  asg_far_src far (.i_gate_idx(gsrc), .i_tb_idx(tsrc), .i_st_idx(ssrc),
    .i_gate_lvl(glvl), .i_tb_run(trun), .i_st_lvl(slvl), .o_pins(pins));
  asg_scan_timing #(.SI_W(16), .SLOW_DIV(SLOW), .FAST_DIV(FAST)) uut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_pfi_zero(pins[0]),
    .i_trig_line(pins[6:1]), .i_star(pins[7]), .i_gate_src(gsrc),
    .i_gate_inv(ginv), .i_tb_src(tsrc), .i_tb_sel(tsel), .i_tb_inv(tinv),
    .i_si_reload(rl), .i_ext_start(ext), .i_start_src(ssrc),
    .i_start_inv(sinv), .i_seq_active(seq), .i_sw_gate(sw),
    .i_conv_strobe(strobe), .i_hold_en(hen), .i_hold_inv(hinv),
    .o_scan_start_q(st), .o_scan_gated_q(gated), .o_hold_done_q(hold));
  function automatic int exp_cnt(input int m, input int r);
    return 3200 / ((m == 0 ? FAST * 4 : m == 1 ? SLOW * 4 : 50) * (r + 1));
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(42938));
    repeat (4) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 12; i++) begin
      seq = 0;
      mode = i % 4;
      {gsrc, ginv, tinv, sinv, hinv} = 7'($urandom);
      rl = 16'($urandom_range(3));
      glvl = ginv ^ ($urandom_range(3) == 0);
      sw = $urandom_range(3) == 0;
      hen = $urandom_range(3) != 0;
      tsel = mode == 3 ? 2'h0 : 2'(mode);
      ext = mode == 3;
      trun = mode == 2;
      slvl = sinv;
      // Let synchronisers and reload settle before the sequence starts
      repeat (4) @(negedge clk);
      seq = $urandom_range(4) != 0;
      blk = (glvl ^ ginv) | sw | !seq;
      repeat (60) @(negedge clk);
      cnt = 0;
      for (int c = 0; c < 800; c++) begin
        if (ext && c % 160 == 40) slvl = !sinv;
        if (ext && c % 160 == 120) slvl = sinv;
        @(negedge clk);
        cnt += st;
      end
      e = blk ? 0 : (ext ? 5 : exp_cnt(mode, rl));
      check("scan starts", (cnt == e + 1 && !ext) ? e : cnt,
            e);
      if (seq) check("gate state", gated, (glvl ^ ginv) | sw);
      strobe = 1;
      @(negedge clk);
      strobe = 0;
      first = -1;
      last = -1;
      for (int c = 1; c < 200; c++) begin
        if (hold !== hinv) last = c;
        if (hold !== hinv && first < 0) first = c;
        @(negedge clk);
      end
      check("hold lead", first >= 14 && first <= 26, hen & seq);
      check("hold width", last - first >= 99 && last - first <= 124,
            hen & seq);
      check("hold idle", hold, hinv);
      $display("test %0d mode %0d done", i, mode);
    end
    end_of_test();
  end
endmodule
